// *** slx_defines.svh ***
// Purpose: constants for the serial link extended-features register bank
// Assumes: byte offsets into configuration space, 32-bit registers
// Notes:   included by the register bank module only
// Summary of operation
// R1: the serial block sits at 0x0100 and the lane block at 0x0400, in that order.
// R2: each block's first word holds its type id and the next-block pointer, 0x0 ends the chain.
// R3: registers decode as block base plus offset: 0x0, 0x20, 0x24, 0x3C, 0x40 and 0x44.
// R4: the header is read only, pointer in 31:16, id 0x0002 with software recovery else 0x0001.
// R5: the link timeout value in bits 31:8 is writable and times ack and link-response waits.
// R6: a timeout lasts the value times a line-rate step of 224, 240, 192, 256 or 205 ns.
// R7: the response timeout value in bits 31:8 times a request until its response, same steps.
// R8: each increment of a timeout value adds one equal step, from zero to the field maximum; the code times a value of zero as one step, like one.
// R9: the general control bits exist once for the device and apply to every port.
// R10: general control bit 31 is the writable host flag with a build-time reset value.
// R11: general control bit 30 permits requests; while 0 user requests are refused.
// R12: general control bit 29 is the writable discovered flag.
// R13: every write to the maintenance request register sends one link-request symbol.
// R14: request bits 2:0 hold the command, reset to zero, carried in the link-request.
// R15: the maintenance request register exists only with software-assisted recovery built in.
// R16: a received link response sets the valid flag at 0x44, which clears when read.
// R17: reserved bits and offsets read zero and ignore writes.
`ifndef SLX_DEFINES_SVH
`define SLX_DEFINES_SVH
`define SLX_SERIAL_BASE   24'h00_0100
`define SLX_LANE_BASE     16'h0400
`define SLX_OFF_HEADER    8'h00
`define SLX_OFF_LINK_TMO  8'h20
`define SLX_OFF_RESP_TMO  8'h24
`define SLX_OFF_GEN_CTL   8'h3C
`define SLX_OFF_LREQ      8'h40
`define SLX_OFF_LRESP     8'h44
`define SLX_ID_SWREC      16'h0002
`define SLX_ID_PLAIN      16'h0001
`define SLX_TMO_MSB       31
`define SLX_TMO_LSB       8
`define SLX_GC_HOST       31
`define SLX_GC_REQ_EN     30
`define SLX_GC_DISC       29
`define SLX_LREQ_CMD_RST  3'h0
`define SLX_RSP_VALID     31
`define SLX_CLK_PERIOD_NS 9'h005
`define SLX_STEP_1G25_NS  9'h0E0
`define SLX_STEP_2G5_NS   9'h0F0
`define SLX_STEP_3G125_NS 9'h0C0
`define SLX_STEP_5G_NS    9'h100
`define SLX_STEP_6G25_NS  9'h0CD
`endif

// *** slx_link_peer.sv ***
// Purpose: far end of the link, answers each link-request with a link-response
// Assumes: one link-request in flight at a time
// Notes:   response fields carry the command so the bench can pair them
module slx_link_peer
   import slx_pkg::*;
#(
   parameter int DELAY = 6
)
(
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       lreq_send,
   input  wire logic [2:0] lreq_cmd,
   output slx_lresp_t      lresp
);
   timeunit 1ns;
   timeprecision 1ps;
   int         cnt;
   logic [2:0] cmd;
   logic       hit;

   assign hit = (cnt == 1);

   // count down to the answer; fields toggle when not valid
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt   <= 0;
         cmd   <= 3'h0;
         lresp <= '0;
      end
      else
      begin
         lresp.valid  <= hit;
         lresp.ackid  <= hit ? {3'h5, cmd} : ~lresp.ackid;
         lresp.status <= hit ? {2'h2, cmd} : ~lresp.status;
         cnt          <= lreq_send ? DELAY : (cnt != 0 ? cnt - 1 : 0);
         cmd          <= lreq_send ? lreq_cmd : cmd;
      end
   end
endmodule

// *** slx_pkg.sv ***
// Purpose: shared types of the serial link register bank
// Assumes: slx_defines.svh holds the offsets, field positions and step lengths; the line-rate codes are set here
// Notes:   structs carry grouped signals across the module ports
package slx_pkg;
   typedef enum logic [2:0] {
      SLX_RATE_1G25  = 3'b000,
      SLX_RATE_2G5   = 3'b001,
      SLX_RATE_3G125 = 3'b010,
      SLX_RATE_5G    = 3'b011,
      SLX_RATE_6G25  = 3'b100
   } slx_rate_t;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [23:0] addr;
      logic [31:0] wdata;
   } slx_cfg_req_t;
   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } slx_cfg_rsp_t;
   typedef struct packed {
      logic       valid;
      logic [5:0] ackid;
      logic [4:0] status;
   } slx_lresp_t;
endpackage

// *** slx_regs.sv ***
// Purpose: serial link extended-features registers, timeout timers, link-request launch
// Assumes: configuration accesses arrive on one clock, answered one cycle later
// Notes:   the lane block header at 0x0400 is outside this bank and reads zero here
`include "slx_defines.svh"
module slx_regs
   import slx_pkg::*;
#(
   parameter bit          SW_RECOVERY  = 1'b1,
   parameter logic [15:0] NEXT_PTR     = `SLX_LANE_BASE,
   parameter slx_rate_t   LINE_RATE    = SLX_RATE_3G125,
   parameter logic [23:0] LINK_TMO_RST = 24'hFF_FFFF,
   parameter logic [23:0] RESP_TMO_RST = 24'hFF_FFFF,
   parameter bit          HOST_RST     = 1'b0,
   parameter bit          REQ_EN_RST   = 1'b1,
   parameter bit          DISC_RST     = 1'b0
)
(
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire slx_cfg_req_t cfg_req,
   output slx_cfg_rsp_t      cfg_rsp,
   input  wire logic         usr_req_valid,
   output logic              usr_req_ready,
   input  wire logic         core_req_ready,
   input  wire logic [1:0]   tmo_start,
   input  wire logic [1:0]   tmo_stop,
   output logic [1:0]        tmo_expired,
   output logic              lreq_send,
   output logic [2:0]        lreq_cmd,
   input  wire slx_lresp_t   lresp
);

   // address decode within the serial block
   // R3: block base plus register offset
   wire [23:0] blk_base = `SLX_SERIAL_BASE;
   wire        in_blk   = cfg_req.addr[23:8] == blk_base[23:8];
   wire [7:0]  off      = cfg_req.addr[7:0];
   wire        acc_wr   = cfg_req.valid && cfg_req.write && in_blk;
   wire        acc_rd   = cfg_req.valid && !cfg_req.write && in_blk;
   wire        hit_hdr  = off == `SLX_OFF_HEADER;
   wire        hit_ltmo = off == `SLX_OFF_LINK_TMO;
   wire        hit_rtmo = off == `SLX_OFF_RESP_TMO;
   wire        hit_gctl = off == `SLX_OFF_GEN_CTL;
   // R15: maintenance pair only with recovery
   wire        hit_lreq = SW_RECOVERY && off == `SLX_OFF_LREQ;
   wire        hit_lrsp = SW_RECOVERY && off == `SLX_OFF_LRESP;

   logic [23:0] link_tmo;
   logic [23:0] resp_tmo;
   logic [2:0]  gen_ctl;
   logic        rsp_flag;
   logic [5:0]  rsp_ackid;
   logic [4:0]  rsp_status;

   // R4: fixed header word, pointer then id
   wire [15:0] type_id  = SW_RECOVERY ? `SLX_ID_SWREC : `SLX_ID_PLAIN;
   // R1: pointer leads to the lane block
   // R2: first word, type id low and next pointer high
   wire [31:0] hdr_word = {NEXT_PTR, type_id};

   // read data mux, reserved bits and offsets give zero
   // R17: reserved space reads zero
   wire [31:0] rd_mux =
      !in_blk  ? 32'h0000_0000 :
      hit_hdr  ? hdr_word :
      hit_ltmo ? {link_tmo, 8'h00} :
      hit_rtmo ? {resp_tmo, 8'h00} :
      hit_gctl ? {gen_ctl, 29'h0000_0000} :
      hit_lreq ? {29'h0000_0000, lreq_cmd} :
      hit_lrsp ? {rsp_flag, 20'h0_0000, rsp_ackid, rsp_status} :
      32'h0000_0000;

   // answer every access one cycle after it is taken
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_rsp <= '0;
      end
      else
      begin
         cfg_rsp.ack   <= cfg_req.valid;
         cfg_rsp.rdata <= (cfg_req.valid && !cfg_req.write) ? rd_mux : 32'h0000_0000;
      end
   end

   // timeout values, shared by all ports
   // R5: link timeout write
   // R7: response timeout write
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         link_tmo <= LINK_TMO_RST;
         resp_tmo <= RESP_TMO_RST;
      end
      else
      begin
         if (acc_wr && hit_ltmo)
            link_tmo <= cfg_req.wdata[`SLX_TMO_MSB:`SLX_TMO_LSB];
         if (acc_wr && hit_rtmo)
            resp_tmo <= cfg_req.wdata[`SLX_TMO_MSB:`SLX_TMO_LSB];
      end
   end

   // R9: one device-wide copy of general control
   // R10: host flag, R12: discovered flag
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         gen_ctl <= {HOST_RST, REQ_EN_RST, DISC_RST};
      else if (acc_wr && hit_gctl)
         gen_ctl <= cfg_req.wdata[`SLX_GC_HOST:`SLX_GC_DISC];
   end

   // R11: user requests refused while permit low
   wire req_en = gen_ctl[`SLX_GC_REQ_EN - `SLX_GC_DISC];
   assign usr_req_ready = core_req_ready && req_en;

   // R13: each write launches one link-request
   // R14: command field held and sent
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lreq_cmd  <= `SLX_LREQ_CMD_RST;
         lreq_send <= 1'b0;
      end
      else
      begin
         lreq_send <= acc_wr && hit_lreq;
         if (acc_wr && hit_lreq)
            lreq_cmd <= cfg_req.wdata[2:0];
      end
   end

   // R16: response capture, valid clears on read, set wins
   wire rsp_read = acc_rd && hit_lrsp;
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rsp_flag   <= 1'b0;
         rsp_ackid  <= 6'h00;
         rsp_status <= 5'h00;
      end
      else if (SW_RECOVERY && lresp.valid)
      begin
         rsp_flag   <= 1'b1;
         rsp_ackid  <= lresp.ackid;
         rsp_status <= lresp.status;
      end
      else if (rsp_read)
         rsp_flag <= 1'b0;
   end

   // R6: line-rate step, the same for both timers
   wire [8:0] step_ns =
      (LINE_RATE == SLX_RATE_1G25) ? `SLX_STEP_1G25_NS :
      (LINE_RATE == SLX_RATE_2G5)  ? `SLX_STEP_2G5_NS :
      (LINE_RATE == SLX_RATE_5G)   ? `SLX_STEP_5G_NS :
      (LINE_RATE == SLX_RATE_6G25) ? `SLX_STEP_6G25_NS :
      `SLX_STEP_3G125_NS;
   wire [1:0] step_tick;

   // timer 0 link, timer 1 response
   logic [23:0] tmo_cnt [2];
   logic [8:0]  ns_acc  [2];
   logic [1:0]  tmo_run;
   wire  [23:0] tmo_lim [2];
   assign tmo_lim[0] = link_tmo;
   assign tmo_lim[1] = resp_tmo;

   for (genvar i = 0; i < 2; i++)
   begin : g_tmr
      // own fractional ns accumulator, restarted with its timer so the
      // first step is a full one and the long-run step length is exact
      wire [9:0]  ns_sum  = {1'b0, ns_acc[i]} + {1'b0, `SLX_CLK_PERIOD_NS};
      wire [9:0]  ns_left = ns_sum - {1'b0, step_ns};
      wire [24:0] cnt_inc = {1'b0, tmo_cnt[i]} + 25'h000_0001;
      wire        reach   = cnt_inc >= {1'b0, tmo_lim[i]};
      assign step_tick[i] = ns_sum >= {1'b0, step_ns};

      // R6: step accumulator advances only while its timer runs
      always_ff @(posedge sys_clk or negedge rstn)
      begin
         if (!rstn)
            ns_acc[i] <= 9'h000;
         else if (tmo_start[i])
            ns_acc[i] <= 9'h000;
         else if (tmo_run[i])
            ns_acc[i] <= step_tick[i] ? ns_left[8:0] : ns_sum[8:0];
      end

      // R8: one equal step per count
      always_ff @(posedge sys_clk or negedge rstn)
      begin
         if (!rstn)
         begin
            tmo_cnt[i]     <= 24'h00_0000;
            tmo_run[i]     <= 1'b0;
            tmo_expired[i] <= 1'b0;
         end
         else
         begin
            tmo_expired[i] <= 1'b0;
            if (tmo_start[i])
            begin
               tmo_cnt[i] <= 24'h00_0000;
               tmo_run[i] <= 1'b1;
            end
            else if (tmo_stop[i])
               tmo_run[i] <= 1'b0;
            else if (tmo_run[i] && step_tick[i])
            begin
               if (reach)
               begin
                  tmo_run[i]     <= 1'b0;
                  tmo_expired[i] <= 1'b1;
               end
               else
                  tmo_cnt[i] <= cnt_inc[23:0];
            end
         end
      end
   end

   // checks on the bank's own registers and outputs
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   sequence s_lreq_write;
      cfg_req.valid && cfg_req.write && in_blk && hit_lreq;
   endsequence

   sequence s_lreq_launch;
      lreq_send ##1 !lreq_send;
   endsequence

   a_cfg_answer: assert property ( // R3
      cfg_req.valid |=> cfg_rsp.ack)
      else $error("access not answered next cycle");

   a_hdr_read_fixed: assert property ( // R4
      cfg_req.valid && !cfg_req.write && in_blk && hit_hdr |=> cfg_rsp.rdata == hdr_word)
      else $error("header read wrong");

   a_rsvd_zero: assert property ( // R17
      cfg_req.valid && !cfg_req.write && !in_blk |=> cfg_rsp.rdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_lreq_one_symbol: assert property ( // R13
      s_lreq_write ##1 !(acc_wr && hit_lreq) |-> s_lreq_launch)
      else $error("link-request not a single pulse");

   a_lreq_cmd_sent: assert property ( // R14
      lreq_send |-> lreq_cmd == $past(cfg_req.wdata[2:0]))
      else $error("link-request command wrong");

   a_req_refused: assert property ( // R11
      !req_en |-> !usr_req_ready)
      else $error("request taken while not permitted");

   a_rsp_flag_set: assert property ( // R16
      SW_RECOVERY && lresp.valid |=> rsp_flag [*1] ##0 rsp_ackid == $past(lresp.ackid))
      else $error("link response not captured");

   a_rsp_read_clear: assert property ( // R16
      rsp_read && !lresp.valid |=> !rsp_flag)
      else $error("response flag not cleared by read");

   a_ltmo_write: assert property ( // R5
      cfg_req.valid && cfg_req.write && in_blk && hit_ltmo
      |=> link_tmo == $past(cfg_req.wdata[31:8]))
      else $error("link timeout not written");

   a_tmo_expire_cause: assert property ( // R6
      tmo_expired[0] |-> $past(tmo_run[0]) && $past(step_tick[0]) && !tmo_run[0])
      else $error("link timeout fired without a step");

   a_req_held_off: assert property ( // R11
      usr_req_valid && !req_en |-> !usr_req_ready)
      else $error("user request offered ready while not permitted");

   a_lreq_no_stray: assert property ( // R13
      lreq_send |-> $past(acc_wr && hit_lreq))
      else $error("link-request sent without a write");

   a_rtmo_write: assert property ( // R7
      acc_wr && hit_rtmo
      |=> resp_tmo == $past(cfg_req.wdata[31:8]))
      else $error("response timeout not written");

   a_gctl_write: assert property ( // R10
      acc_wr && hit_gctl
      |=> gen_ctl == $past(cfg_req.wdata[31:29]))
      else $error("general control not written");

   a_tmo_stop_quiet: assert property ( // R7
      tmo_stop[1] && !tmo_start[1] |=> !tmo_expired[1])
      else $error("response timeout fired after a stop");

endmodule

// *** tb.sv ***
// Purpose: self-checking bench of the serial link register bank
// Assumes: peer answers each link-request after a few cycles
// Notes:   timeouts are shortened by writing small values
module tb
   import slx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic         sys_clk = 1'b0;
   logic         rstn = 1'b0;
   slx_cfg_req_t req = '0;
   slx_cfg_rsp_t rsp;
   logic         usr_req_ready;
   logic         core_req_ready = 1'b1;
   logic         lreq_send;
   logic [1:0]   tmo_start = 2'h0;
   logic [1:0]   tmo_stop = 2'h0;
   logic [1:0]   tmo_expired;
   logic [2:0]   lreq_cmd;
   slx_lresp_t   lresp;
   logic [31:0]  d;
   logic [23:0]  rsv [7] = '{24'h00_0100, 24'h00_0104, 24'h00_011C, 24'h00_0128,
                             24'h00_0138, 24'h00_01FC, 24'h00_0400};
   int           err_count = 0;
   int           tests_run = 0;

   always #2.5 sys_clk = ~sys_clk;

   slx_regs dut (.sys_clk(sys_clk), .rstn(rstn), .cfg_req(req), .cfg_rsp(rsp),
      .usr_req_valid(1'b1), .usr_req_ready(usr_req_ready), .core_req_ready(core_req_ready),
      .tmo_start(tmo_start), .tmo_stop(tmo_stop), .tmo_expired(tmo_expired),
      .lreq_send(lreq_send), .lreq_cmd(lreq_cmd), .lresp(lresp));

   slx_link_peer peer (.sys_clk(sys_clk), .rstn(rstn), .lreq_send(lreq_send),
      .lreq_cmd(lreq_cmd), .lresp(lresp));

   task automatic print_verdict();
      if (err_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one access; the answer is sampled in the cycle after the request
   task automatic acc(input logic wr, input logic [23:0] a, input logic [31:0] w,
                      output logic [31:0] r);
      @(posedge sys_clk) #1;
      req = '{valid: 1'b1, write: wr, addr: a, wdata: w};
      @(posedge sys_clk) #1;
      req.valid = 1'b0;
      chk({31'h0, rsp.ack}, 32'h1);
      r = rsp.rdata;
   endtask

   task automatic rdc(input logic [23:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0, d);
      chk(d, exp);
   endtask

   // start a timer, optionally stop it, and time the expiry pulse
   task automatic tmo(input int k, input int v, input bit stop);
      int n;
      int e;
      acc(1'b1, k ? 24'h00_0124 : 24'h00_0120, 32'(v) << 8, d);
      e = v * 192 / 5;
      @(posedge sys_clk) #1;
      tmo_start[k] = 1'b1;
      @(posedge sys_clk) #1;
      tmo_start[k] = 1'b0;
      tmo_stop[k] = stop;
      n = 1;
      while (tmo_expired[k] !== 1'b1 && n < e + 20)
      begin
         @(posedge sys_clk) #1;
         tmo_stop[k] = 1'b0;
         n++;
      end
      if (stop)
         chk(32'(n), 32'(e + 20));
      else
         chk(32'(n >= e - 4 && n <= e + 4), 32'h1);
      if (!stop && n >= e + 20)
         print_verdict();
   endtask

   initial
   begin
      repeat (20) @(posedge sys_clk);
      #1 rstn = 1'b1;
      // reset values
      rdc(24'h00_0100, 32'h0400_0002);
      rdc(24'h00_0120, 32'hFFFF_FF00);
      rdc(24'h00_0124, 32'hFFFF_FF00);
      rdc(24'h00_013C, 32'h4000_0000);
      rdc(24'h00_0140, 32'h0000_0000);
      rdc(24'h00_0144, 32'h0000_0000);
      // read-only and reserved places ignore writes
      foreach (rsv[i])
      begin
         acc(1'b1, rsv[i], 32'hFFFF_FFFF, d);
         chk({31'h0, lreq_send}, 32'h0);
         rdc(rsv[i], rsv[i] == 24'h00_0100 ? 32'h0400_0002 : 32'h0);
      end
      acc(1'b1, 24'h00_0120, 32'h1234_56FF, d);
      rdc(24'h00_0120, 32'h1234_5600);
      acc(1'b1, 24'h00_0124, 32'hA5A5_A5A5, d);
      rdc(24'h00_0124, 32'hA5A5_A500);
      // general control bits and the request permit
      acc(1'b1, 24'h00_013C, 32'hE000_0000, d);
      rdc(24'h00_013C, 32'hE000_0000);
      chk({31'h0, usr_req_ready}, 32'h1);
      acc(1'b1, 24'h00_013C, 32'h1FFF_FFFF, d);
      rdc(24'h00_013C, 32'h0000_0000);
      chk({31'h0, usr_req_ready}, 32'h0);
      acc(1'b1, 24'h00_013C, 32'h4000_0000, d);
      core_req_ready = 1'b0;
      @(posedge sys_clk) #1;
      chk({31'h0, usr_req_ready}, 32'h0);
      core_req_ready = 1'b1;
      // every link-request command and its response
      for (int c = 0; c < 8; c++)
      begin
         acc(1'b1, 24'h00_0140, 32'hFFFF_FFF8 | 32'(c), d);
         chk({28'h0, lreq_send, lreq_cmd}, {29'h1, 3'(c)});
         rdc(24'h00_0140, 32'(c));
         d = 32'h0;
         for (int i = 0; i < 20 && d[31] !== 1'b1; i++)
            acc(1'b0, 24'h00_0144, 32'h0, d);
         chk(d, {1'b1, 20'h0, 3'h5, 3'(c), 2'h2, 3'(c)});
         if (d[31] !== 1'b1)
            print_verdict();
         acc(1'b0, 24'h00_0144, 32'h0, d);
         chk({31'h0, d[31]}, 32'h0);
      end
      // timers scale linearly; a stop cancels the expiry
      tmo(0, 2, 1'b0);
      tmo(0, 4, 1'b0);
      tmo(1, 2, 1'b0);
      tmo(1, 5, 1'b0);
      tmo(0, 3, 1'b1);
      tmo(1, 3, 1'b1);
      // a second reset restores the build values
      acc(1'b1, 24'h00_013C, 32'hA000_0000, d);
      @(posedge sys_clk) #1 rstn = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 rstn = 1'b1;
      rdc(24'h00_0120, 32'hFFFF_FF00);
      rdc(24'h00_013C, 32'h4000_0000);
      print_verdict();
   end
endmodule
